// ---- fpc_map.vh ----
// Constants for the flash parameter check and 128-byte program sequencer.
// Assumes a 32-bit byte address space with flash at a fixed window.
`ifndef FPC_MAP_VH
`define FPC_MAP_VH

// Frequency code limits, MHz times 100
`define FPC_FREQ_MIN        16'h0320
`define FPC_FREQ_MAX        16'h07D0
`define FPC_FREQ_HI_MSB     31
`define FPC_FREQ_HI_LSB     16
`define FPC_FREQ_LO_MSB     15
`define FPC_FREQ_LO_LSB     0

// Result byte bit positions
`define FPC_BIT_PASS_FAIL   0
`define FPC_BIT_FREQ_ERR    1
`define FPC_BIT_DEST_ERR    1
`define FPC_BIT_SRC_ERR     2
`define FPC_RESULT_ZERO     8'h00

// Flash address window, inclusive
`define FPC_FLASH_BASE      32'h00000000
`define FPC_FLASH_LAST      32'h0003FFFF

// Programming unit
`define FPC_UNIT_BYTES      8'h80
`define FPC_UNIT_LAST       7'h7F
`define FPC_ALIGN_MSB       6
`define FPC_ZERO7           7'h00
`define FPC_ONE7            7'h01

// Reset values and index padding
`define FPC_ADDR_ZERO       32'h00000000
`define FPC_DATA_ZERO       8'h00
`define FPC_ADDR_PAD        25'h0

`endif

// ---- fpc_param_check.v ----
// Flash parameter check and 128-byte program sequencer.
// Assumes a byte read port to source memory answering in one cycle
// and a byte write port to the user memory array that may stall.
// All inputs come from logic on ref_clk; none are resynchronised.
// Clock enable low holds every register, outputs included.
// Function
// - Initialization accepts frequency codes for 8 to 20 MHz only.
// - Result bit 1 set when the frequency code is out of range.
// - Result bit 0 is 0 on success, 1 on any init error.
// - Unused upper bits of init result read as zero.
// - Destination outside flash space is flagged as an error.
// - Misaligned destination sets result bit 1.
// - Source pointer inside flash sets the source error bit.
// - Each program that passes the checks writes 128 consecutive bytes from the destination.
// - Source bytes fetched consecutively and written in order.
`timescale 1ns/1ps
`include "fpc_map.vh"

module fpc_param_check (
    input  wire        ref_clk,
    input  wire        rst_b,
    input  wire        clk_en,
    input  wire        init_start,
    input  wire        prog_start,
    input  wire [31:0] frequency_code_param,
    input  wire [31:0] program_destination_address,
    input  wire [31:0] program_source_pointer,
    output wire        busy,
    output reg         done_r,
    output reg  [7:0]  result_byte_r,
    output reg         src_rd_r,
    output reg  [31:0] src_addr_r,
    input  wire [7:0]  src_data,
    output reg         mem_wr_r,
    output reg  [31:0] mem_addr_r,
    output reg  [7:0]  mem_data_r,
    input  wire        mem_ready
);

    // One-hot states
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_READ  = 4'b0010;
    localparam [3:0] ST_WRITE = 4'b0100;
    localparam [3:0] ST_WAIT  = 4'b1000;

    reg  [3:0]  state_r;
    reg  [6:0]  count_r;
    reg  [31:0] dest_base_r;
    reg  [31:0] src_base_r;

    // Next values of every register
    reg  [3:0]  state_nxt;
    reg  [6:0]  count_nxt;
    reg  [31:0] dest_base_nxt;
    reg  [31:0] src_base_nxt;
    reg         done_nxt;
    reg  [7:0]  result_byte_nxt;
    reg         src_rd_nxt;
    reg  [31:0] src_addr_nxt;
    reg         mem_wr_nxt;
    reg  [31:0] mem_addr_nxt;
    reg  [7:0]  mem_data_nxt;

    wire [15:0] freq_val;
    wire        freq_err;
    wire        dest_out;
    wire        dest_misalign;
    wire        src_in_flash;
    wire        prog_err;

    // Result bytes and byte index helpers
    reg  [7:0]  init_result;
    reg  [7:0]  prog_result;
    wire [31:0] byte_offset;
    wire        last_byte;

    assign freq_val = frequency_code_param[`FPC_FREQ_LO_MSB:`FPC_FREQ_LO_LSB];
    assign freq_err = (freq_val < `FPC_FREQ_MIN) || (freq_val > `FPC_FREQ_MAX);
    assign dest_out = (program_destination_address < `FPC_FLASH_BASE) ||
                      (program_destination_address > `FPC_FLASH_LAST);
    // Low seven bits must be zero
    assign dest_misalign =
        (program_destination_address[`FPC_ALIGN_MSB:0] != `FPC_ZERO7);
    // Source pointer must not hit flash
    assign src_in_flash = (program_source_pointer >= `FPC_FLASH_BASE) &&
                          (program_source_pointer <= `FPC_FLASH_LAST);
    assign prog_err = dest_out || dest_misalign || src_in_flash;

    // Handshake output, combinational
    assign busy = (state_r != ST_IDLE);

    // Init result byte, unused bits low
    always @* begin
        init_result                     = `FPC_RESULT_ZERO;
        init_result[`FPC_BIT_FREQ_ERR]  = freq_err;
        init_result[`FPC_BIT_PASS_FAIL] = freq_err;
    end

    always @* begin
        prog_result                     = `FPC_RESULT_ZERO;
        prog_result[`FPC_BIT_DEST_ERR]  = dest_out | dest_misalign;
        prog_result[`FPC_BIT_SRC_ERR]   = src_in_flash;
        prog_result[`FPC_BIT_PASS_FAIL] = prog_err;
    end

    // Byte index widened to an address offset
    assign byte_offset = {`FPC_ADDR_PAD, count_r};

    // Last byte of the 128-byte unit
    assign last_byte   = (count_r == `FPC_UNIT_LAST);

    // Next-state logic; registers hold unless a state moves them
    always @* begin
        state_nxt       = state_r;
        count_nxt       = count_r;
        dest_base_nxt   = dest_base_r;
        src_base_nxt    = src_base_r;
        result_byte_nxt = result_byte_r;
        src_addr_nxt    = src_addr_r;
        mem_wr_nxt      = mem_wr_r;
        mem_addr_nxt    = mem_addr_r;
        mem_data_nxt    = mem_data_r;
        // Strobes are single-cycle pulses
        done_nxt        = 1'b0;
        src_rd_nxt      = 1'b0;

        case (state_r)
            ST_IDLE: begin
                // Init wins over program when both are high
                if (init_start) begin
                    result_byte_nxt = init_result;
                    done_nxt        = 1'b1;
                end else if (prog_start) begin
                    result_byte_nxt = prog_result;
                    if (prog_err) begin
                        done_nxt = 1'b1; // Write skipped entirely
                    end else begin
                        // Bases latched for the whole unit
                        dest_base_nxt = program_destination_address;
                        src_base_nxt  = program_source_pointer;
                        count_nxt     = `FPC_ZERO7;
                        state_nxt     = ST_READ;
                    end
                end
            end
            ST_READ: begin
                // Consecutive source fetch
                // Source must answer by the next edge
                src_rd_nxt   = 1'b1;
                src_addr_nxt = src_base_r + byte_offset;
                state_nxt    = ST_WRITE;
            end
            ST_WRITE: begin
                // Byte lands at destination plus index
                mem_wr_nxt   = 1'b1;
                mem_addr_nxt = dest_base_r + byte_offset;
                mem_data_nxt = src_data;
                state_nxt    = ST_WAIT;
            end
            ST_WAIT: begin
                // Hold the write until the array takes it
                // A slow array simply stretches this state
                if (mem_ready) begin
                    mem_wr_nxt = 1'b0;
                    if (last_byte) begin
                        done_nxt  = 1'b1;
                        state_nxt = ST_IDLE;
                    end else begin
                        count_nxt = count_r + `FPC_ONE7;
                        state_nxt = ST_READ;
                    end
                end
            end
            default: begin
                // Illegal code: recover to idle, drop the write
                state_nxt  = ST_IDLE;
                mem_wr_nxt = 1'b0;
            end
        endcase
    end

    // Registers; reset is asynchronous, clock enable low freezes all
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            // Outputs low while reset is held
            state_r       <= ST_IDLE;
            count_r       <= `FPC_ZERO7;
            dest_base_r   <= `FPC_ADDR_ZERO;
            src_base_r    <= `FPC_ADDR_ZERO;
            done_r        <= 1'b0;
            result_byte_r <= `FPC_RESULT_ZERO;
            src_rd_r      <= 1'b0;
            src_addr_r    <= `FPC_ADDR_ZERO;
            mem_wr_r      <= 1'b0;
            mem_addr_r    <= `FPC_ADDR_ZERO;
            mem_data_r    <= `FPC_DATA_ZERO;
        end else if (clk_en) begin
            // Take the next values only on enabled edges
            state_r       <= state_nxt;
            count_r       <= count_nxt;
            dest_base_r   <= dest_base_nxt;
            src_base_r    <= src_base_nxt;
            done_r        <= done_nxt;
            result_byte_r <= result_byte_nxt;
            src_rd_r      <= src_rd_nxt;
            src_addr_r    <= src_addr_nxt;
            mem_wr_r      <= mem_wr_nxt;
            mem_addr_r    <= mem_addr_nxt;
            mem_data_r    <= mem_data_nxt;
        end
    end

endmodule // fpc_param_check

// ---- fpc_param_check_checker.sv ----
// Port-level checker for the flash parameter check sequencer.
// Assumes one request in flight; clk_en low freezes the counters too.
`timescale 1ns/1ps
`include "fpc_map.vh"
module fpc_param_check_checker (
    input wire        ref_clk, rst_b, clk_en, init_start, prog_start,
    input wire        busy, done_r, src_rd_r, mem_wr_r, mem_ready,
    input wire [31:0] frequency_code_param, program_destination_address,
    input wire [31:0] program_source_pointer, src_addr_r, mem_addr_r,
    input wire [7:0]  result_byte_r
);
    logic [6:0]  n_wr;
    logic [31:0] last_rd;
    wire  [15:0] fq = frequency_code_param[15:0];
    wire bad_dst = program_destination_address > `FPC_FLASH_LAST
                   || |program_destination_address[6:0];
    wire bad_src = program_source_pointer <= `FPC_FLASH_LAST;
    // Write count wraps once per 128-byte unit
    always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b) begin
            n_wr <= 7'h00;
            last_rd <= 32'h00000000;
        end else begin
            if (clk_en && mem_wr_r && mem_ready) n_wr <= n_wr + 7'h01;
            if (clk_en && src_rd_r) last_rd <= src_addr_r;
        end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_init; clk_en && !busy && init_start; endsequence
    sequence s_prog; clk_en && !busy && !init_start && prog_start; endsequence
    a_upper_bits_zero: assert property (done_r |-> !(|result_byte_r[7:3]))
        else $error("result upper bits set");
    a_init_zero: assert property (s_init |=> result_byte_r[7:2] == 6'h00)
        else $error("init result unused bits set");
    a_fail_flag: assert property (done_r |-> result_byte_r[0] == |result_byte_r[2:1])
        else $error("fail bit disagrees with error bits");
    a_freq_flag: assert property (s_init |=> done_r && result_byte_r[1] ==
        ($past(fq) < `FPC_FREQ_MIN || $past(fq) > `FPC_FREQ_MAX)) else $error("bad freq flag");
    a_dest_flag: assert property (s_prog |=> result_byte_r[1] == $past(bad_dst))
        else $error("bad destination flag");
    a_src_flag: assert property (s_prog |=> result_byte_r[2] == $past(bad_src))
        else $error("bad source flag");
    a_skip_write: assert property (s_prog ##1 result_byte_r[0] |->
        done_r && !busy && !mem_wr_r ##1 (!src_rd_r && !mem_wr_r)
        ##1 !mem_wr_r) else $error("write after failed check");
    a_dest_order: assert property (mem_wr_r |-> mem_addr_r[6:0] == n_wr)
        else $error("destination out of order");
    a_src_order: assert property (src_rd_r && n_wr != 7'h00 |-> src_addr_r == last_rd + 32'h1)
        else $error("source not consecutive");
endmodule // fpc_param_check_checker
bind fpc_param_check fpc_param_check_checker fpc_param_check_checker_i (
    .ref_clk, .rst_b, .clk_en, .init_start, .prog_start, .busy, .done_r,
    .src_rd_r, .mem_wr_r, .mem_ready, .frequency_code_param, .src_addr_r,
    .program_destination_address, .program_source_pointer, .mem_addr_r,
    .result_byte_r);

// ---- fpc_mem_model.sv ----
// Source memory and user memory array stand-in for the sequencer.
// Assumes one access at a time; stall makes writes slow to accept.
`timescale 1ns/1ps
module fpc_mem_model (
    input  wire        ref_clk, src_rd_r, mem_wr_r, stall,
    input  wire [31:0] src_addr_r, mem_addr_r,
    input  wire [7:0]  mem_data_r,
    output logic [7:0] src_data,
    output logic       mem_ready
);
    logic [7:0] ary [0:255];
    logic [1:0] tick = 2'h0;
    // address-pattern source for any address, answers while read strobe stands
    // Inverse pattern when not read, so a late sample shows up
    assign src_data = src_rd_r ? (src_addr_r[7:0] ^ src_addr_r[15:8] ^ 8'h3C)
                               : ~(src_addr_r[7:0] ^ src_addr_r[15:8] ^ 8'h3C);
    always @(posedge ref_clk) begin
        tick <= tick + 2'h1;
        if (mem_wr_r && mem_ready) ary[mem_addr_r[7:0]] <= mem_data_r;
    end
    // Slow mode accepts one cycle in four
    assign mem_ready = mem_wr_r && (!stall || tick == 2'h3);
endmodule // fpc_mem_model

// ---- tb_fpc_param_check.sv ----
// Self-checking bench for the flash parameter check sequencer.
// Assumes the memory model sits on the source and write ports.
`timescale 1ns/1ps
module tb_fpc_param_check;
    logic        ref_clk = 1'b0, rst_b = 1'b0, init_start = 1'b0;
    logic        prog_start = 1'b0, stall = 1'b0, clk_en = 1'b1, was_busy;
    logic [31:0] fr = 32'h0, dst = 32'h0, src = 32'h0;
    wire         busy, done_r, src_rd_r, mem_wr_r, mem_ready;
    wire  [31:0] src_addr_r, mem_addr_r;
    wire  [7:0]  result_byte_r, mem_data_r, src_data;
    int          n_fail = 0, num_checks = 0;
    fpc_param_check fpc_param_check_i (.ref_clk, .rst_b, .clk_en,
        .init_start, .prog_start, .frequency_code_param(fr), .busy, .done_r,
        .program_destination_address(dst), .program_source_pointer(src),
        .result_byte_r, .src_rd_r, .src_addr_r, .src_data, .mem_wr_r,
        .mem_addr_r, .mem_data_r, .mem_ready);
    fpc_mem_model fpc_mem_model_i (.ref_clk, .src_rd_r, .mem_wr_r, .stall,
        .src_addr_r, .mem_addr_r, .mem_data_r, .src_data, .mem_ready);
    function automatic logic [7:0] pat(input logic [31:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    task automatic chk(input logic [7:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One-cycle request, then a bounded wait for the done pulse
    task automatic run(input logic ini, input logic [31:0] a, b);
        @(negedge ref_clk);
        fr = a;
        dst = a;
        src = b;
        init_start = ini;
        prog_start = !ini;
        @(negedge ref_clk);
        init_start = 1'b0;
        prog_start = 1'b0;
        was_busy = busy;
        for (int i = 0; i < 3000 && done_r !== 1'b1; i++) @(negedge ref_clk);
        chk({7'h00, done_r}, 8'h01);
    endtask
    task automatic fq(input logic [31:0] c, input logic [7:0] exp);
        run(1'b1, c, 32'h0);
        chk(result_byte_r, exp);
    endtask
    // Good units are read back byte by byte from the array
    task automatic prog(input logic [31:0] d, s, input logic [7:0] exp);
        run(1'b0, d, s);
        chk(result_byte_r, exp);
        chk({7'h00, was_busy}, {7'h00, exp == 8'h00});
        for (int k = 0; k < 128 && exp == 8'h00; k++)
            chk(fpc_mem_model_i.ary[8'(d[7:0] + k)], pat(s + k));
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial forever #2.5 ref_clk = ~ref_clk;
    initial begin
        #40000;
        n_fail++;
        give_verdict;
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        fq(32'h00000320, 8'h00);
        fq(32'h000007D0, 8'h00);
        fq(32'h0000031F, 8'h03);
        fq(32'h000007D1, 8'h03);
        fq(32'h00000000, 8'h03);
        // Clock enable low holds a pending init request
        @(negedge ref_clk);
        clk_en = 1'b0;
        fr = 32'h000003E8;
        init_start = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk({7'h00, done_r}, 8'h00);
        clk_en = 1'b1;
        @(negedge ref_clk);
        init_start = 1'b0;
        chk({7'h00, done_r}, 8'h01);
        chk(result_byte_r, 8'h00);
        prog(32'h00000100, 32'h00040005, 8'h00);
        stall = 1'b1;
        prog(32'h0003FF80, 32'h80000000, 8'h00);
        stall = 1'b0;
        prog(32'h00000140, 32'h00040000, 8'h03);
        prog(32'h00040000, 32'h00040000, 8'h03);
        prog(32'h00000200, 32'h0003FFFF, 8'h05);
        prog(32'h00040001, 32'h00000000, 8'h07);
        give_verdict;
    end
endmodule // tb_fpc_param_check
